// ### logic/fscs_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  frame-synchronised configuration shadow. Assumes a 9-bit register address
  carried by the serial port and 16-bit register data.
*/
// Functional notes
// - frame-related changes reach the active set only at a frame boundary.
// - a frame needing extra settling is blanked; data and sync send training.
// - subsampling and binning bits take effect at the next frame start.
// - rolling shutter: dark or filler row change blanks exactly one frame.
// - global shutter: dark or filler row changes never blank a frame.
// - rolling shutter with window-switch option set: blank after switch.
// - a switch counts only when the active window selection changes.
// - resizing the active window never blanks a frame.
// - exposure applies one frame late, except triggered master sync mode.
// - gain changes apply at the start of a new frame.
// - gain latency option delays gain one more frame to match exposure.
// - all gate bits share one register; a low gate keeps old settings.
// - a high gate lets pending writes reach the active set at frame start.
// - row-length gate low freezes the rolling row length.
// - dark-row and filler-row gates freeze their own counts.
// - exposure gate freezes multiplier, frame period and exposure together.
// - gain gate freezes column gain switch and front-end gain together.
// - region gate freezes window selection, subsampling and binning.
// - window geometry writes pass through regardless of the region gate.
// - each of the eight windows is enabled or disabled on its own bit.
`ifndef FSCS_REGS_SVH
`define FSCS_REGS_SVH

// register addresses
`define FSCS_ADDR_SEQ_CTRL 9'h0C0
`define FSCS_ADDR_ROW_LEN 9'h0C1
`define FSCS_ADDR_WIN_MASK 9'h0C3
`define FSCS_ADDR_DARK 9'h0C5
`define FSCS_ADDR_FILLER 9'h0C6
`define FSCS_ADDR_EXP_CTRL 9'h0C7
`define FSCS_ADDR_TIMER_MULT 9'h0C8
`define FSCS_ADDR_FRAME_PERIOD 9'h0C9
`define FSCS_ADDR_EXPOSURE 9'h0CA
`define FSCS_ADDR_GAIN 9'h0CC
`define FSCS_ADDR_GATE 9'h0CE
`define FSCS_ADDR_STATUS 9'h0CF
`define FSCS_ADDR_GEOM_LO 9'h100
`define FSCS_ADDR_GEOM_HI 9'h117

// sequencer_control fields
`define FSCS_SEQ_ENABLE 0
`define FSCS_SEQ_ROLLING 1
`define FSCS_SEQ_TRIGGERED 2
`define FSCS_SEQ_SLAVE 3
`define FSCS_SEQ_SUBSAMPLE 7
`define FSCS_SEQ_BINNING 8

// exposure_timing_control fields
`define FSCS_EXP_SYNC_MODE 14
`define FSCS_EXP_GAIN_LAT 13

// update_gate_control fields
`define FSCS_GATE_ROW_LEN 0
`define FSCS_GATE_DARK 1
`define FSCS_GATE_FILLER 2
`define FSCS_GATE_EXPOSURE 3
`define FSCS_GATE_GAIN 4
`define FSCS_GATE_REGION 5
`define FSCS_GATE_BLANK_WIN 8

// reset values
`define FSCS_RST_GATE 16'h003F
`define FSCS_RST_ZERO 16'h0000

// serial frame: 9 address bits, one write flag, 16 data bits
`define FSCS_SPI_LAST_HDR 5'h09
`define FSCS_SPI_LAST_BIT 5'h19

`endif

// ### logic/fscs_pkg.sv
/*
  Types of the frame-synchronised configuration shadow: the packed state of
  the serial port and of the register bank. Assumes the constants header.
*/
package fscs_pkg;

  // serial port state, one register for the whole module
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [1:0] ss_sync;
    logic [1:0] mosi_sync;
    logic [4:0] cnt;
    logic [25:0] shift;
    logic [15:0] tx;
    logic miso;
    logic wr_stb;
    logic rd_stb;
    logic [8:0] addr;
    logic [15:0] data;
  } fscs_spi_state_t;

  // register bank state: host-written set, staging and active set
  typedef struct packed {
    logic [15:0] seq_ctrl;
    logic [15:0] row_len;
    logic [15:0] win_mask;
    logic [15:0] dark;
    logic [15:0] filler;
    logic [15:0] exp_ctrl;
    logic [15:0] timer_mult;
    logic [15:0] frame_period;
    logic [15:0] exposure;
    logic [15:0] gain;
    logic [15:0] gate;
    logic [15:0] stg_timer_mult;
    logic [15:0] stg_frame_period;
    logic [15:0] stg_exposure;
    logic [15:0] stg_gain;
    logic [15:0] act_row_len;
    logic [15:0] act_dark;
    logic [15:0] act_filler;
    logic [15:0] act_timer_mult;
    logic [15:0] act_frame_period;
    logic [15:0] act_exposure;
    logic [15:0] act_gain;
    logic [7:0] act_win;
    logic act_subsample;
    logic act_binning;
    logic blank;
    logic geom_wr;
    logic [4:0] geom_index;
    logic [15:0] geom_data;
  } fscs_state_t;

endpackage

// ### logic/fscs_spi_port.sv
/*
  Serial register port: samples a 4-wire serial link on the logic clock.
  Assumes the serial clock is far slower than mclk and that the register
  bank answers a read address in the same cycle as the read strobe.
*/
`timescale 1ns/10ps
`include "fscs_regs.svh"

module fscs_spi_port (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // serial pins
  input wire logic spi_sclk,
  input wire logic spi_ss_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // register bank side
  output logic wr_stb,
  output logic rd_stb,
  output logic [8:0] addr,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);

  fscs_pkg::fscs_spi_state_t st;
  fscs_pkg::fscs_spi_state_t next_st;
  logic rise;
  logic fall;

  // edges seen only from the second and third stage, never the first
  assign rise = st.sclk_sync[1] & ~st.sclk_sync[2];
  assign fall = ~st.sclk_sync[1] & st.sclk_sync[2];

  // frame decode: header then data, msb first on rising serial clock
  always_comb begin
    next_st = st;
    next_st.sclk_sync = {st.sclk_sync[1:0], spi_sclk};
    next_st.ss_sync = {st.ss_sync[0], spi_ss_b};
    next_st.mosi_sync = {st.mosi_sync[0], spi_mosi};
    next_st.wr_stb = 1'b0;
    next_st.rd_stb = 1'b0;
    if (st.rd_stb) begin
      next_st.tx = rdata; // read word loaded while the address is stable
    end
    if (st.ss_sync[1]) begin
      next_st.cnt = 5'h00;
    end else if (rise) begin
      next_st.shift = {st.shift[24:0], st.mosi_sync[1]};
      next_st.cnt = st.cnt + 5'h01;
      if (st.cnt == `FSCS_SPI_LAST_HDR && !st.mosi_sync[1]) begin
        next_st.addr = st.shift[8:0];
        next_st.rd_stb = 1'b1;
      end
      if (st.cnt == `FSCS_SPI_LAST_BIT && st.shift[15]) begin
        next_st.addr = st.shift[24:16];
        next_st.data = {st.shift[14:0], st.mosi_sync[1]};
        next_st.wr_stb = 1'b1;
      end
    end else if (fall && st.cnt > `FSCS_SPI_LAST_HDR) begin
      next_st.miso = st.tx[15];
      next_st.tx = {st.tx[14:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.sclk_sync <= 3'h0;
      st.ss_sync <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign spi_miso = st.miso;
  assign spi_miso_oe = ~st.ss_sync[1];
  assign wr_stb = st.wr_stb;
  assign rd_stb = st.rd_stb;
  assign addr = st.addr;
  assign wdata = st.data;

endmodule

// ### logic/fscs_shadow.sv
/*
  Frame-synchronised configuration shadow: holds the host-written register
  set, moves it into the active set at frame start under per-group gates,
  and blanks a frame with training patterns when a change needs settling.
  Assumes frame_start is a one-cycle pulse from the sequencer on mclk and
  that the serial pins are asynchronous to mclk.
*/
`timescale 1ns/10ps
`include "fscs_regs.svh"

module fscs_shadow (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // serial register port
  input wire logic spi_sclk,
  input wire logic spi_ss_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // sequencer events
  input wire logic frame_start,
  // static sequencer mode, straight from the host set
  output logic seq_enable,
  output logic rolling_mode,
  output logic triggered_mode,
  output logic slave_mode,
  // active set used by the sequencer
  output logic [15:0] rolling_row_length,
  output logic [15:0] dark_rows,
  output logic [15:0] filler_rows,
  output logic [15:0] timer_multiplier,
  output logic [15:0] frame_period,
  output logic [15:0] exposure_value,
  output logic [15:0] gain_value,
  output logic [7:0] window_enable_mask,
  output logic subsample_en,
  output logic binning_en,
  // blanking and training
  output logic frame_blank,
  output logic data_training,
  output logic sync_training,
  // window geometry pass-through
  output logic geom_wr,
  output logic [4:0] geom_index,
  output logic [15:0] geom_data
);

  fscs_pkg::fscs_state_t st;
  fscs_pkg::fscs_state_t next_st;

  logic wr_stb;
  logic [8:0] bus_addr;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;

  logic gate_row_len;
  logic gate_dark;
  logic gate_filler;
  logic gate_exposure;
  logic gate_gain;
  logic gate_region;
  logic blank_on_switch;
  logic exp_direct;
  logic gain_lat_comp;
  logic dark_change;
  logic filler_change;
  logic window_switch;
  logic need_blank;

  // serial port; pins are synchronised inside it
  fscs_spi_port u_spi (
    .mclk(mclk),
    .rst_b(rst_b),
    .spi_sclk(spi_sclk),
    .spi_ss_b(spi_ss_b),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .wr_stb(wr_stb),
    .rd_stb(),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .rdata(bus_rdata)
  );

  // all gate bits live in one register
  assign gate_row_len = st.gate[`FSCS_GATE_ROW_LEN];
  assign gate_dark = st.gate[`FSCS_GATE_DARK];
  assign gate_filler = st.gate[`FSCS_GATE_FILLER];
  assign gate_exposure = st.gate[`FSCS_GATE_EXPOSURE];
  assign gate_gain = st.gate[`FSCS_GATE_GAIN];
  assign gate_region = st.gate[`FSCS_GATE_REGION];
  assign blank_on_switch = st.gate[`FSCS_GATE_BLANK_WIN];

  // exposure bypasses the staging only in triggered master sync mode
  assign exp_direct = st.exp_ctrl[`FSCS_EXP_SYNC_MODE]
    & st.seq_ctrl[`FSCS_SEQ_TRIGGERED] & ~st.seq_ctrl[`FSCS_SEQ_SLAVE];
  assign gain_lat_comp = st.exp_ctrl[`FSCS_EXP_GAIN_LAT];

  // a row count change is only real when the gate lets it through
  assign dark_change = gate_dark && st.dark != st.act_dark;
  assign filler_change = gate_filler && st.filler != st.act_filler;

  // only a new selection of active windows is a switch, not a resize
  assign window_switch = gate_region
    && st.win_mask[7:0] != st.act_win;

  // rolling shutter alone needs the row reset pointers rebuilt
  assign need_blank = st.seq_ctrl[`FSCS_SEQ_ROLLING]
    && (dark_change || filler_change
    || (blank_on_switch && window_switch));

  // read mux: host set plus a status word of the live state
  always_comb begin
    unique case (bus_addr)
      `FSCS_ADDR_SEQ_CTRL: bus_rdata = st.seq_ctrl;
      `FSCS_ADDR_ROW_LEN: bus_rdata = st.row_len;
      `FSCS_ADDR_WIN_MASK: bus_rdata = st.win_mask;
      `FSCS_ADDR_DARK: bus_rdata = st.dark;
      `FSCS_ADDR_FILLER: bus_rdata = st.filler;
      `FSCS_ADDR_EXP_CTRL: bus_rdata = st.exp_ctrl;
      `FSCS_ADDR_TIMER_MULT: bus_rdata = st.timer_mult;
      `FSCS_ADDR_FRAME_PERIOD: bus_rdata = st.frame_period;
      `FSCS_ADDR_EXPOSURE: bus_rdata = st.exposure;
      `FSCS_ADDR_GAIN: bus_rdata = st.gain;
      `FSCS_ADDR_GATE: bus_rdata = st.gate;
      `FSCS_ADDR_STATUS: bus_rdata = {5'h00, st.blank, st.act_binning,
        st.act_subsample, st.act_win};
      default: bus_rdata = 16'h0000; // unmapped and geometry read as zero
    endcase
  end

  // next state: host writes, frame-start transfer and blanking
  always_comb begin
    next_st = st;
    next_st.geom_wr = 1'b0;

    // host writes land in the pending set only, except geometry writes, which go straight out
    if (wr_stb) begin
      unique case (bus_addr)
        `FSCS_ADDR_SEQ_CTRL: next_st.seq_ctrl = bus_wdata;
        `FSCS_ADDR_ROW_LEN: next_st.row_len = bus_wdata;
        `FSCS_ADDR_WIN_MASK: next_st.win_mask = bus_wdata;
        `FSCS_ADDR_DARK: next_st.dark = bus_wdata;
        `FSCS_ADDR_FILLER: next_st.filler = bus_wdata;
        `FSCS_ADDR_EXP_CTRL: next_st.exp_ctrl = bus_wdata;
        `FSCS_ADDR_TIMER_MULT: next_st.timer_mult = bus_wdata;
        `FSCS_ADDR_FRAME_PERIOD: next_st.frame_period = bus_wdata;
        `FSCS_ADDR_EXPOSURE: next_st.exposure = bus_wdata;
        `FSCS_ADDR_GAIN: next_st.gain = bus_wdata;
        `FSCS_ADDR_GATE: next_st.gate = bus_wdata;
        default: begin
        end
      endcase
      // geometry is never shadowed, the region gate does not hold it
      if (bus_addr >= `FSCS_ADDR_GEOM_LO
          && bus_addr <= `FSCS_ADDR_GEOM_HI) begin
        next_st.geom_wr = 1'b1;
        next_st.geom_index = 5'(bus_addr - `FSCS_ADDR_GEOM_LO);
        next_st.geom_data = bus_wdata;
      end
    end

    // transfer happens only on the boundary, mid-frame stays untouched
    if (frame_start) begin
      // blank lasts exactly the frame that starts now
      next_st.blank = need_blank;

      // each open group copies all fields in this one cycle
      if (gate_row_len) begin
        next_st.act_row_len = st.row_len;
      end
      if (gate_dark) begin
        next_st.act_dark = st.dark;
      end
      if (gate_filler) begin
        next_st.act_filler = st.filler;
      end

      // exposure group moves as one block, through the stage unless exp_direct
      if (gate_exposure) begin
        next_st.stg_timer_mult = st.timer_mult;
        next_st.stg_frame_period = st.frame_period;
        next_st.stg_exposure = st.exposure;
        if (exp_direct) begin
          next_st.act_timer_mult = st.timer_mult;
          next_st.act_frame_period = st.frame_period;
          next_st.act_exposure = st.exposure;
        end else begin
          next_st.act_timer_mult = st.stg_timer_mult;
          next_st.act_frame_period = st.stg_frame_period;
          next_st.act_exposure = st.stg_exposure;
        end
      end

      // gain at frame start, optionally one more frame late
      if (gate_gain) begin
        next_st.stg_gain = st.gain;
        next_st.act_gain = gain_lat_comp ? st.stg_gain : st.gain;
      end

      // window selection travels with subsampling and binning
      if (gate_region) begin
        next_st.act_win = st.win_mask[7:0];
        next_st.act_subsample = st.seq_ctrl[`FSCS_SEQ_SUBSAMPLE];
        next_st.act_binning = st.seq_ctrl[`FSCS_SEQ_BINNING];
      end
    end
  end

  // single state register; gates open after reset so writes flow by default
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.gate <= `FSCS_RST_GATE;
    end else begin
      st <= next_st;
    end
  end

  // static mode bits are used as written, they may change only when idle
  assign seq_enable = st.seq_ctrl[`FSCS_SEQ_ENABLE];
  assign rolling_mode = st.seq_ctrl[`FSCS_SEQ_ROLLING];
  assign triggered_mode = st.seq_ctrl[`FSCS_SEQ_TRIGGERED];
  assign slave_mode = st.seq_ctrl[`FSCS_SEQ_SLAVE];

  // active set straight from flip-flops
  assign rolling_row_length = st.act_row_len;
  assign dark_rows = st.act_dark;
  assign filler_rows = st.act_filler;
  assign timer_multiplier = st.act_timer_mult;
  assign frame_period = st.act_frame_period;
  assign exposure_value = st.act_exposure;
  assign gain_value = st.act_gain;
  assign window_enable_mask = st.act_win;
  assign subsample_en = st.act_subsample;
  assign binning_en = st.act_binning;

  // training replaces image data and sync for the blanked frame
  assign frame_blank = st.blank;
  assign data_training = st.blank;
  assign sync_training = st.blank;

  // geometry strobe, one cycle per host write
  assign geom_wr = st.geom_wr;
  assign geom_index = st.geom_index;
  assign geom_data = st.geom_data;

endmodule

// ### sim/fscs_shadow_monitor.sv
/*
  Concurrent checks of the configuration shadow, bound to its top module.
  Assumes frame_start is a one-cycle pulse on mclk.
*/
`timescale 1ns/10ps

module fscs_shadow_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // serial select and miso enable
  input wire logic spi_ss_b,
  input wire logic spi_miso_oe,
  // frame event and mode
  input wire logic frame_start,
  input wire logic rolling_mode,
  // active set
  input wire logic [15:0] rolling_row_length,
  input wire logic [15:0] dark_rows,
  input wire logic [15:0] filler_rows,
  input wire logic [15:0] exposure_value,
  input wire logic [15:0] gain_value,
  input wire logic [7:0] window_enable_mask,
  input wire logic subsample_en,
  input wire logic binning_en,
  // blanking and geometry
  input wire logic frame_blank,
  input wire logic data_training,
  input wire logic sync_training,
  input wire logic geom_wr
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // a row count moved at a rolling frame start
  sequence row_moved_s;
    frame_start && rolling_mode ##1 (dark_rows != $past(dark_rows) ||
      filler_rows != $past(filler_rows));
  endsequence
  // select seen low long enough to pass the synchroniser
  sequence sel_s;
    !spi_ss_b [*5];
  endsequence

  // active values move only right after a frame start
  row_hold_a: assert property (!frame_start |=> $stable({dark_rows,
    filler_rows, rolling_row_length, exposure_value, gain_value}))
    else $error("active row or exposure value moved mid frame");
  region_hold_a: assert property (!frame_start |=> $stable(
    {window_enable_mask, subsample_en, binning_en}))
    else $error("region selection moved mid frame");
  train_tied_a: assert property (data_training == frame_blank &&
    sync_training == frame_blank)
    else $error("training outputs differ from blank");
  blank_edge_a: assert property ($changed(frame_blank) |->
    $past(frame_start))
    else $error("blank changed away from a frame start");
  global_quiet_a: assert property (frame_start && !rolling_mode
    |=> !frame_blank)
    else $error("global shutter frame was blanked");
  row_blank_a: assert property (row_moved_s |-> frame_blank)
    else $error("row count change did not blank the frame");
  geom_pulse_a: assert property (geom_wr |=> !geom_wr)
    else $error("geometry strobe longer than one cycle");
  oe_sel_a: assert property (sel_s |-> spi_miso_oe)
    else $error("miso not driven while selected");
endmodule

// ### sim/fscs_spi_host.sv
/*
  Serial host model: drives 26-bit frames, msb first, sclk idle low.
  Assumes mclk from the bench; each sclk phase lasts 8 mclk.
*/
`timescale 1ns/10ps

module fscs_spi_host (
  // clock
  input wire logic mclk,
  // serial pins
  output logic spi_sclk,
  output logic spi_ss_b,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  logic miso_line;

  // released line reads high, as through a pull-up
  assign miso_line = spi_miso_oe ? spi_miso : 1'b1;

  initial begin
    spi_sclk = 1'b0;
    spi_ss_b = 1'b1;
    spi_mosi = 1'b0;
  end

  // one frame; read bits sampled on the last 16 rising edges
  task automatic xfer(input logic [8:0] a, input logic rw,
      input logic [15:0] d, output logic [15:0] q);
    logic [25:0] f;
    f = {a, rw, d};
    q = 16'h0000;
    @(posedge mclk) spi_ss_b <= 1'b0;
    for (int i = 25; i >= 0; i--) begin
      spi_mosi <= f[i];
      repeat (8) @(posedge mclk);
      spi_sclk <= 1'b1;
      if (i < 16) q = {q[14:0], miso_line};
      repeat (8) @(posedge mclk);
      spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    spi_ss_b <= 1'b1;
    spi_mosi <= ~spi_mosi; // released: no stale data bit
    repeat (4) @(posedge mclk);
  endtask
endmodule

// ### sim/fscs_shadow_tb.sv
/*
  Self-checking bench of the configuration shadow: register access through
  the serial host model, frame start pulses, expected active values.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/10ps
`include "fscs_regs.svh"

module fscs_shadow_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic frame_start = 1'b0;
  logic sclk, ss_b, mosi, miso, miso_oe;
  logic en, rolling, trig, slave, subs, binn, blank, dtr, st, gwr;
  logic [15:0] row_len, dark, filler, tmult, fper, expo, gain, gd, gdat, rd;
  logic [7:0] win;
  logic [4:0] gi, gidx;
  int error_cnt = 0;
  int checked = 0;

  // 250 MHz logic clock
  always #2 mclk = ~mclk;

  fscs_shadow dut (.mclk(mclk), .rst_b(rst_b), .spi_sclk(sclk),
    .spi_ss_b(ss_b), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe(miso_oe), .frame_start(frame_start), .seq_enable(en),
    .rolling_mode(rolling), .triggered_mode(trig), .slave_mode(slave),
    .rolling_row_length(row_len), .dark_rows(dark), .filler_rows(filler),
    .timer_multiplier(tmult), .frame_period(fper), .exposure_value(expo),
    .gain_value(gain), .window_enable_mask(win), .subsample_en(subs),
    .binning_en(binn), .frame_blank(blank), .data_training(dtr),
    .sync_training(st), .geom_wr(gwr), .geom_index(gi), .geom_data(gd));

  fscs_spi_host u_host (.mclk(mclk), .spi_sclk(sclk), .spi_ss_b(ss_b),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe));

  // keep the last geometry strobe, it lasts one cycle only
  always @(posedge mclk) begin
    if (gwr === 1'b1) begin
      gidx <= gi;
      gdat <= gd;
    end
  end

  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bchk(input logic e);
    chk("blank", {15'h0000, blank}, {15'h0000, e});
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    u_host.xfer(a, 1'b1, d, rd);
  endtask

  task automatic rdchk(input logic [8:0] a, input logic [15:0] e);
    u_host.xfer(a, 1'b0, 16'h0000, rd);
    chk("read", rd, e);
  endtask

  // one frame start, then let the transfer land
  task automatic fs();
    @(posedge mclk) frame_start <= 1'b1;
    @(posedge mclk) frame_start <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // 38 transfers of some 430 cycles each fit well inside
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    // reset values, read-write access and a missing address
    rdchk(`FSCS_ADDR_GATE, `FSCS_RST_GATE);
    wr(`FSCS_ADDR_SEQ_CTRL, 16'h0181);
    rdchk(`FSCS_ADDR_SEQ_CTRL, 16'h0181);
    wr(9'h0D0, 16'h1234);
    rdchk(9'h0D0, 16'h0000);
    $display("test access done");
    // global mode: new values wait for the frame start
    wr(`FSCS_ADDR_DARK, 16'h0005);
    wr(`FSCS_ADDR_GAIN, 16'h0022);
    chk("dark", dark, 16'h0000);
    chk("sub bin", {14'h0000, binn, subs}, 16'h0000);
    fs();
    chk("dark", dark, 16'h0005);
    chk("gain", gain, 16'h0022);
    chk("sub bin", {14'h0000, binn, subs}, 16'h0003);
    bchk(1'b0);
    $display("test frame sync done");
    // exposure goes through staging; gain follows with its option
    wr(`FSCS_ADDR_FRAME_PERIOD, 16'h0200);
    wr(`FSCS_ADDR_EXPOSURE, 16'h0100);
    fs();
    chk("expo", expo, 16'h0000);
    fs();
    chk("expo", expo, 16'h0100);
    chk("period", fper, 16'h0200);
    wr(`FSCS_ADDR_EXP_CTRL, 16'h2000);
    fs();
    wr(`FSCS_ADDR_GAIN, 16'h0033);
    fs();
    chk("gain", gain, 16'h0022);
    fs();
    chk("gain", gain, 16'h0033);
    $display("test latency done");
    // closed gates keep the old active set, reopening moves row counts at once, exposure and gain one frame later
    wr(`FSCS_ADDR_GATE, 16'h0000);
    wr(`FSCS_ADDR_DARK, 16'h0007);
    wr(`FSCS_ADDR_FILLER, 16'h0009);
    wr(`FSCS_ADDR_ROW_LEN, 16'h0040);
    wr(`FSCS_ADDR_EXPOSURE, 16'h0111);
    wr(`FSCS_ADDR_TIMER_MULT, 16'h0003);
    wr(`FSCS_ADDR_GAIN, 16'h0044);
    fs();
    fs();
    chk("dark", dark, 16'h0005);
    chk("filler", filler, 16'h0000);
    chk("row", row_len, 16'h0000);
    chk("expo", expo, 16'h0100);
    chk("gain", gain, 16'h0033);
    wr(`FSCS_ADDR_GATE, 16'h003F);
    fs();
    chk("dark", dark, 16'h0007);
    chk("filler", filler, 16'h0009);
    chk("row", row_len, 16'h0040);
    fs();
    chk("expo", expo, 16'h0111);
    chk("mult", tmult, 16'h0003);
    chk("gain", gain, 16'h0044);
    $display("test gates done");
    // rolling shutter: a filler count change blanks one frame
    wr(`FSCS_ADDR_SEQ_CTRL, 16'h0183);
    chk("mode", {12'h000, slave, trig, rolling, en}, 16'h0003);
    wr(`FSCS_ADDR_FILLER, 16'h000A);
    fs();
    bchk(1'b1);
    chk("train", {14'h0000, dtr, st}, 16'h0003);
    fs();
    bchk(1'b0);
    $display("test rolling done");
    // window switch with the blank option, region gate closed and open
    wr(`FSCS_ADDR_GATE, 16'h013F);
    wr(`FSCS_ADDR_WIN_MASK, 16'h0001);
    fs();
    bchk(1'b1);
    chk("mask", {8'h00, win}, 16'h0001);
    wr(`FSCS_ADDR_GATE, 16'h011F);
    wr(`FSCS_ADDR_WIN_MASK, 16'h0002);
    wr(`FSCS_ADDR_SEQ_CTRL, 16'h0003);
    wr(9'h105, 16'h0ABC);
    chk("geom index", {11'h000, gidx}, 16'h0005);
    chk("geom data", gdat, 16'h0ABC);
    fs();
    bchk(1'b0);
    chk("mask", {8'h00, win}, 16'h0001);
    chk("sub bin", {14'h0000, binn, subs}, 16'h0003);
    wr(`FSCS_ADDR_GATE, 16'h013F);
    fs();
    bchk(1'b1);
    chk("mask", {8'h00, win}, 16'h0002);
    chk("sub bin", {14'h0000, binn, subs}, 16'h0000);
    wr(`FSCS_ADDR_WIN_MASK, 16'h0002);
    wr(9'h106, 16'h0111);
    chk("geom data", gdat, 16'h0111);
    fs();
    bchk(1'b0);
    wr(`FSCS_ADDR_GATE, 16'h003F);
    wr(`FSCS_ADDR_WIN_MASK, 16'h0080);
    fs();
    bchk(1'b0);
    chk("mask", {8'h00, win}, 16'h0080);
    $display("test windows done");
    // triggered master with sync mode: exposure applies at once
    wr(`FSCS_ADDR_SEQ_CTRL, 16'h0005);
    wr(`FSCS_ADDR_EXP_CTRL, 16'h4000);
    wr(`FSCS_ADDR_EXPOSURE, 16'h0555);
    fs();
    chk("expo", expo, 16'h0555);
    // a slave sequencer never takes the direct path
    wr(`FSCS_ADDR_SEQ_CTRL, 16'h000D);
    chk("mode", {12'h000, slave, trig, rolling, en}, 16'h000D);
    wr(`FSCS_ADDR_EXPOSURE, 16'h0666);
    fs();
    chk("expo", expo, 16'h0555);
    rdchk(`FSCS_ADDR_STATUS, 16'h0080);
    $display("test direct done");
    summarize();
  end
endmodule

bind fscs_shadow fscs_shadow_monitor u_mon (.mclk(mclk), .rst_b(rst_b),
  .spi_ss_b(spi_ss_b), .spi_miso_oe(spi_miso_oe),
  .frame_start(frame_start), .rolling_mode(rolling_mode),
  .rolling_row_length(rolling_row_length), .dark_rows(dark_rows),
  .filler_rows(filler_rows), .exposure_value(exposure_value),
  .gain_value(gain_value), .window_enable_mask(window_enable_mask),
  .subsample_en(subsample_en), .binning_en(binning_en),
  .frame_blank(frame_blank), .data_training(data_training),
  .sync_training(sync_training), .geom_wr(geom_wr));
